// >>> hdl/swgc_pkg.sv
// constants, field layout and timing of the switch global control bank
package swgc_pkg;
  // register addresses seen over the serial management port
  localparam logic [7:0]  REG_GC0_ADDR      = 8'h02;
  localparam logic [7:0]  REG_GC1_ADDR      = 8'h03;
  // global_control_zero fields
  localparam int          GC0_RSVD_BIT      = 7;
  localparam int          GC0_PRIO_LSB      = 4;
  localparam int          GC0_MII_EN_BIT    = 3;
  localparam int          GC0_SHARE_BIT     = 2;
  localparam int          GC0_INTEROP_BIT   = 1;
  localparam int          GC0_LINK_AGE_BIT  = 0;
  localparam logic [7:0]  GC0_RESET         = 8'h4C;
  // global_control_one fields, bits 2..0 are not held here and read zero
  localparam int          GC1_PASS_ALL_BIT  = 7;
  localparam int          GC1_RSVD_BIT      = 6;
  localparam int          GC1_TX_FC_DIS_BIT = 5;
  localparam int          GC1_RX_FC_DIS_BIT = 4;
  localparam int          GC1_LEN_CHK_BIT   = 3;
  localparam int          GC1_HELD_LSB      = 3;
  localparam logic [7:0]  GC1_RESET         = 8'h00;
  // serial port command bytes
  localparam logic [7:0]  SPI_CMD_WRITE     = 8'h02;
  localparam logic [7:0]  SPI_CMD_READ      = 8'h03;
  // frame classification constants
  localparam logic [15:0] PAUSE_TYPE        = 16'h8808;
  localparam logic [47:0] PAUSE_DA          = 48'h0180C2000001;
  localparam logic [15:0] LEN_FIELD_MAX     = 16'h05DC;
  // timing
  localparam int          CLK_PERIOD_NS     = 8;
  localparam int          FAST_AGE_MAX_NS   = 800000;
  localparam int          FAST_AGE_CYC      = FAST_AGE_MAX_NS / CLK_PERIOD_NS;
  localparam int          AGE_NORMAL_S      = 300;
  localparam int          AGE_SPREAD_S      = 75;
  localparam logic [1:0]  STRAP_WAIT        = 2'h2;
  localparam int          NUM_PORTS         = 5;
  localparam int          BUF_SHARE_DIV     = 5;

  typedef enum logic [2:0] {SP_CMD, SP_ADDR, SP_WDATA, SP_RDATA, SP_SKIP} swgc_spi_phase_t;
endpackage : swgc_pkg

// >>> hdl/swgc_cfg_if.sv
// control bits carried from the register bank to the frame policy logic
`timescale 1ns/1ns
`default_nettype none
interface swgc_cfg_if;
  logic [2:0] base_prio;
  logic       interop_test_drop_mode;
  logic       link_change_age;
  logic       pass_all;
  logic       len_check;

  modport regs (output base_prio, interop_test_drop_mode, link_change_age, pass_all, len_check);
  modport pol  (input  base_prio, interop_test_drop_mode, link_change_age, pass_all, len_check);
endinterface : swgc_cfg_if
`default_nettype wire

// >>> hdl/swgc_frame_policy.sv
// per-frame decision and address-table aging requests
`timescale 1ns/1ns
`default_nettype none
module swgc_frame_policy
  import swgc_pkg::*;
#(
  parameter int FAST_AGE_CYCLES = FAST_AGE_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  swgc_cfg_if.pol                   cfg,
  input  wire logic                 frm_valid,
  input  wire logic                 frm_tagged,
  input  wire logic [2:0]           frm_user_prio,
  input  wire logic [15:0]          frm_type_len,
  input  wire logic [47:0]          frm_da,
  input  wire logic                 frm_is_flow_ctrl,
  input  wire logic [15:0]          frm_payload_len,
  input  wire logic                 frm_errored,
  input  wire logic [NUM_PORTS-1:0] link_up,
  output logic                      dec_valid_q,
  output logic                      dec_high_prio_q,
  output logic                      dec_drop_q,
  output logic                      dec_mirror_q,
  output logic                      age_flush_q,
  output logic                      age_fast_q
);
  localparam int CW = $clog2(FAST_AGE_CYCLES + 1);

  if (FAST_AGE_CYCLES < 1) begin : g_bad_fast_age
    $error("fast age count must be at least one cycle");
  end

  logic                 dec_valid_d, dec_high_prio_d, dec_drop_d, dec_mirror_d;
  logic                 age_flush_d, age_fast_d;
  logic [NUM_PORTS-1:0] link_prev_q, link_prev_d;
  logic [CW-1:0]        age_cnt_q, age_cnt_d;
  logic                 link_lost;
  logic                 ctl_drop, len_bad;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    link_lost       = |(link_prev_q & ~link_up);
    link_prev_d     = link_up;
    dec_valid_d     = frm_valid;
    dec_high_prio_d = dec_high_prio_q;
    dec_drop_d      = dec_drop_q;
    dec_mirror_d    = dec_mirror_q;
    // interop mode widens the pause filter to the raw type and address match
    ctl_drop = cfg.interop_test_drop_mode ? (frm_type_len == PAUSE_TYPE || frm_da == PAUSE_DA)
                                          : frm_is_flow_ctrl;               // [R4]
    len_bad  = cfg.len_check && frm_type_len < LEN_FIELD_MAX
               && frm_type_len != frm_payload_len;                          // [R11]
    if (frm_valid) begin
      // untagged frames carry no user priority and fall to the low class
      dec_high_prio_d = frm_tagged && frm_user_prio >= cfg.base_prio;       // [R1]
      dec_drop_d      = ctl_drop || len_bad || (frm_errored && !cfg.pass_all); // [R7]
      dec_mirror_d    = cfg.pass_all;                                       // [R7]
    end
    age_flush_d = link_lost;                                                // [R6]
    age_fast_d  = age_fast_q;
    age_cnt_d   = age_cnt_q;
    // one fast pass, then back to the normal period
    if (link_lost && cfg.link_change_age) begin
      age_fast_d = 1'b1;                                                    // [R5]
      age_cnt_d  = CW'(FAST_AGE_CYCLES - 1);
    end else if (age_fast_q) begin
      if (age_cnt_q == '0) age_fast_d = 1'b0;                               // [R5]
      else age_cnt_d = age_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_valid_q     <= 1'b0;
      dec_high_prio_q <= 1'b0;
      dec_drop_q      <= 1'b0;
      dec_mirror_q    <= 1'b0;
      age_flush_q     <= 1'b0;
      age_fast_q      <= 1'b0;
      age_cnt_q       <= '0;
      link_prev_q     <= '0;
    end else begin
      dec_valid_q     <= dec_valid_d;
      dec_high_prio_q <= dec_high_prio_d;
      dec_drop_q      <= dec_drop_d;
      dec_mirror_q    <= dec_mirror_d;
      age_flush_q     <= age_flush_d;
      age_fast_q      <= age_fast_d;
      age_cnt_q       <= age_cnt_d;
      link_prev_q     <= link_prev_d;
    end
  end
endmodule : swgc_frame_policy
`default_nettype wire

// >>> hdl/swgc_top.sv
// global control register bank with serial management port and strap capture
// How it works
// R1: tagged frames whose user priority is at or above the 3-bit base priority (reset 4) are high class, others low.
// R2: clearing the phy mii enable bit tri-states that mii; its reset value comes from the mii enable strap.
// R3: with buffer share set (reset) ports share the whole pool, cleared each port gets one fifth of it.
// R4: interop drop mode drops type 0x8808 or the pause address; otherwise only qualified flow-control frames drop.
// R5: with link change aging set, a link loss starts one fast aging pass, then normal aging resumes.
// R6: any port losing its link ages out every learned address.
// R7: pass all forwards errored frames too, alongside sniffer mirroring; pause and length-check drops still apply; cleared at reset.
// R8: tx flow control disable at 1 forces transmit pause off, at 0 it follows autonegotiation.
// R9: rx flow control disable at 1 forces receive pause off, at 0 it follows autonegotiation.
// R10: both flow control disables load from one shared strap and are then written independently.
// R11: with length check set, frames with length field below 1500 not matching the payload are dropped.
// R12: the management processor reads and writes every global control bit over the serial port; global_control_one bits 2..0 are not held and read zero.
// R13: straps set their bits at reset, other bits take fixed defaults, writes act on the next frame decision.
`timescale 1ns/1ns
`default_nettype none
module swgc_top
  import swgc_pkg::*;
#(
  parameter int BUF_POOL_UNITS  = 1280,
  parameter int FAST_AGE_CYCLES = FAST_AGE_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 spi_sclk,
  input  wire logic                 spi_cs_n,
  input  wire logic                 spi_mosi,
  output logic                      spi_miso,
  output logic                      spi_miso_oe_n,
  input  wire logic                 mii_enable_strap_pin,
  input  wire logic                 flow_control_strap_pin,
  output logic                      phy_mii_oe_n,
  output logic                      buf_shared,
  output logic [15:0]               buf_port_limit,
  input  wire logic [NUM_PORTS-1:0] an_tx_pause,
  input  wire logic [NUM_PORTS-1:0] an_rx_pause,
  output logic [NUM_PORTS-1:0]      tx_pause_en,
  output logic [NUM_PORTS-1:0]      rx_pause_en,
  input  wire logic                 frm_valid,
  input  wire logic                 frm_tagged,
  input  wire logic [2:0]           frm_user_prio,
  input  wire logic [15:0]          frm_type_len,
  input  wire logic [47:0]          frm_da,
  input  wire logic                 frm_is_flow_ctrl,
  input  wire logic [15:0]          frm_payload_len,
  input  wire logic                 frm_errored,
  input  wire logic [NUM_PORTS-1:0] link_up,
  output logic                      dec_valid,
  output logic                      dec_high_prio,
  output logic                      dec_drop,
  output logic                      dec_mirror,
  output logic                      age_flush,
  output logic                      age_fast
);
  if (BUF_POOL_UNITS < BUF_SHARE_DIV || BUF_POOL_UNITS > 65535) begin : g_bad_pool
    $error("buffer pool size out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage one feeds stage two only
  logic [2:0] sclk_sy_q;
  logic [1:0] cs_sy_q, mosi_sy_q, mii_sy_q, fc_sy_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sy_q <= 3'h0;
      cs_sy_q   <= 2'h3;
      mosi_sy_q <= 2'h0;
      mii_sy_q  <= 2'h0;
      fc_sy_q   <= 2'h0;
    end else begin
      sclk_sy_q <= {sclk_sy_q[1:0], spi_sclk};
      cs_sy_q   <= {cs_sy_q[0], spi_cs_n};
      mosi_sy_q <= {mosi_sy_q[0], spi_mosi};
      mii_sy_q  <= {mii_sy_q[0], mii_enable_strap_pin};
      fc_sy_q   <= {fc_sy_q[0], flow_control_strap_pin};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial management slave, mode 0, msb first
  swgc_spi_phase_t phase_q, phase_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, addr_q, addr_d, tx_q, tx_d, sh_next;
  logic       rd_q, rd_d, miso_q, miso_d, oe_n_q, oe_n_d;
  logic       sclk_rise, sclk_fall, selected, byte_done, wr_en;
  logic [7:0] gc0_q, gc0_d;
  logic [4:0] gc1_q, gc1_d;

  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] g0, input logic [4:0] g1);
    logic [7:0] v;
    v = 8'h00;
    if (a == REG_GC0_ADDR) v = g0;                                          // [R12]
    else if (a == REG_GC1_ADDR) v = {g1, 3'h0};                             // [R12]
    return v;
  endfunction : reg_read

  always_comb begin
    sclk_rise = sclk_sy_q[1] && !sclk_sy_q[2];
    sclk_fall = !sclk_sy_q[1] && sclk_sy_q[2];
    selected  = !cs_sy_q[1];
    sh_next   = {sh_q[6:0], mosi_sy_q[1]};
    byte_done = selected && sclk_rise && bit_q == 3'h7;
    wr_en     = byte_done && phase_q == SP_WDATA;
    phase_d   = phase_q;
    bit_d     = bit_q;
    sh_d      = sh_q;
    addr_d    = addr_q;
    tx_d      = tx_q;
    rd_d      = rd_q;
    miso_d    = miso_q;
    oe_n_d    = oe_n_q;
    if (!selected) begin
      phase_d = SP_CMD;
      bit_d   = 3'h0;
      oe_n_d  = 1'b1;
    end else if (sclk_rise) begin
      sh_d  = sh_next;
      bit_d = bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        unique case (phase_q)
          SP_CMD: begin
            rd_d    = sh_next == SPI_CMD_READ;
            phase_d = (sh_next == SPI_CMD_READ || sh_next == SPI_CMD_WRITE) ? SP_ADDR : SP_SKIP;
          end
          SP_ADDR: begin
            addr_d  = sh_next;
            tx_d    = reg_read(sh_next, gc0_q, gc1_q);                     // [R12]
            phase_d = rd_q ? SP_RDATA : SP_WDATA;
          end
          // burst: address steps on after every data byte
          SP_WDATA: addr_d = addr_q + 8'h01;
          SP_RDATA: begin
            addr_d = addr_q + 8'h01;
            tx_d   = reg_read(addr_q + 8'h01, gc0_q, gc1_q);
          end
          SP_SKIP: ;
        endcase
      end
    end else if (sclk_fall && phase_q == SP_RDATA) begin
      miso_d = tx_q[7];
      tx_d   = {tx_q[6:0], 1'b0};
      oe_n_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= SP_CMD;
      bit_q   <= 3'h0;
      sh_q    <= 8'h00;
      addr_q  <= 8'h00;
      tx_q    <= 8'h00;
      rd_q    <= 1'b0;
      miso_q  <= 1'b0;
      oe_n_q  <= 1'b1;
    end else begin
      phase_q <= phase_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      addr_q  <= addr_d;
      tx_q    <= tx_d;
      rd_q    <= rd_d;
      miso_q  <= miso_d;
      oe_n_q  <= oe_n_d;
    end
  end

  assign spi_miso      = miso_q;
  assign spi_miso_oe_n = oe_n_q;

  //////////////////////////////////////////////////////////////////////////////
  // register bank; straps are caught once the synchronisers hold real pin levels
  logic [1:0]           strap_cnt_q, strap_cnt_d;
  logic                 strap_done_q, strap_done_d;
  logic                 mii_oe_n_d, share_d;
  logic [15:0]          limit_d;
  logic [NUM_PORTS-1:0] txp_d, rxp_d;

  always_comb begin
    gc0_d        = gc0_q;
    gc1_d        = gc1_q;
    strap_cnt_d  = strap_cnt_q;
    strap_done_d = strap_done_q;
    if (!strap_done_q) begin
      if (strap_cnt_q == STRAP_WAIT) begin
        gc0_d[GC0_MII_EN_BIT] = mii_sy_q[1];                                // [R2] [R13]
        gc1_d[GC1_TX_FC_DIS_BIT-GC1_HELD_LSB] = fc_sy_q[1];                 // [R10]
        gc1_d[GC1_RX_FC_DIS_BIT-GC1_HELD_LSB] = fc_sy_q[1];                 // [R10]
        strap_done_d = 1'b1;
      end else begin
        strap_cnt_d = strap_cnt_q + 2'h1;
      end
    end else if (wr_en && addr_q == REG_GC0_ADDR) begin
      gc0_d = sh_next;                                                      // [R12]
    end else if (wr_en && addr_q == REG_GC1_ADDR) begin
      gc1_d = sh_next[7:GC1_HELD_LSB];                                      // [R10] [R12]
    end
    // derived outputs follow the new register value in the same edge
    mii_oe_n_d = !gc0_d[GC0_MII_EN_BIT];                                    // [R2]
    share_d    = gc0_d[GC0_SHARE_BIT];                                      // [R3]
    limit_d    = share_d ? 16'(BUF_POOL_UNITS) : 16'(BUF_POOL_UNITS / BUF_SHARE_DIV); // [R3]
    txp_d      = an_tx_pause & ~{NUM_PORTS{gc1_d[GC1_TX_FC_DIS_BIT-GC1_HELD_LSB]}}; // [R8]
    rxp_d      = an_rx_pause & ~{NUM_PORTS{gc1_d[GC1_RX_FC_DIS_BIT-GC1_HELD_LSB]}}; // [R9]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gc0_q          <= GC0_RESET;                                          // [R13]
      gc1_q          <= GC1_RESET[7:GC1_HELD_LSB];
      strap_cnt_q    <= 2'h0;
      strap_done_q   <= 1'b0;
      phy_mii_oe_n   <= 1'b0;
      buf_shared     <= GC0_RESET[GC0_SHARE_BIT];
      buf_port_limit <= 16'(BUF_POOL_UNITS);
      tx_pause_en    <= '0;
      rx_pause_en    <= '0;
    end else begin
      gc0_q          <= gc0_d;
      gc1_q          <= gc1_d;
      strap_cnt_q    <= strap_cnt_d;
      strap_done_q   <= strap_done_d;
      phy_mii_oe_n   <= mii_oe_n_d;
      buf_shared     <= share_d;
      buf_port_limit <= limit_d;
      tx_pause_en    <= txp_d;
      rx_pause_en    <= rxp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame policy sees the registered bits, so a write acts on the next frame
  swgc_cfg_if cfg ();

  assign cfg.base_prio              = gc0_q[GC0_PRIO_LSB +: 3];             // [R1]
  assign cfg.interop_test_drop_mode = gc0_q[GC0_INTEROP_BIT];               // [R4]
  assign cfg.link_change_age        = gc0_q[GC0_LINK_AGE_BIT];              // [R5]
  assign cfg.pass_all               = gc1_q[GC1_PASS_ALL_BIT-GC1_HELD_LSB]; // [R7]
  assign cfg.len_check              = gc1_q[GC1_LEN_CHK_BIT-GC1_HELD_LSB];  // [R11] [R13]

  swgc_frame_policy #(
    .FAST_AGE_CYCLES (FAST_AGE_CYCLES)
  ) u_policy (
    .clk              (clk),
    .rst_n            (rst_n),
    .cfg              (cfg),
    .frm_valid        (frm_valid),
    .frm_tagged       (frm_tagged),
    .frm_user_prio    (frm_user_prio),
    .frm_type_len     (frm_type_len),
    .frm_da           (frm_da),
    .frm_is_flow_ctrl (frm_is_flow_ctrl),
    .frm_payload_len  (frm_payload_len),
    .frm_errored      (frm_errored),
    .link_up          (link_up),
    .dec_valid_q      (dec_valid),
    .dec_high_prio_q  (dec_high_prio),
    .dec_drop_q       (dec_drop),
    .dec_mirror_q     (dec_mirror),
    .age_flush_q      (age_flush),
    .age_fast_q       (age_fast)
  );
endmodule : swgc_top
`default_nettype wire

// >>> bench/swgc_assertions.sv
// port-level checks for the switch global control bank
`timescale 1ns/1ns
`default_nettype none
module swgc_assertions
  import swgc_pkg::*;
#(
  parameter int BUF_POOL_UNITS  = 1280,
  parameter int FAST_AGE_CYCLES = FAST_AGE_CYC
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 spi_cs_n,
  input wire logic                 spi_miso_oe_n,
  input wire logic                 buf_shared,
  input wire logic [15:0]          buf_port_limit,
  input wire logic [NUM_PORTS-1:0] an_tx_pause,
  input wire logic [NUM_PORTS-1:0] an_rx_pause,
  input wire logic [NUM_PORTS-1:0] tx_pause_en,
  input wire logic [NUM_PORTS-1:0] rx_pause_en,
  input wire logic                 frm_valid,
  input wire logic                 frm_tagged,
  input wire logic [2:0]           frm_user_prio,
  input wire logic [NUM_PORTS-1:0] link_up,
  input wire logic                 dec_valid,
  input wire logic                 dec_high_prio,
  input wire logic                 age_flush,
  input wire logic                 age_fast
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // cycles of fast aging since the last flush; a restart reloads it
  logic [31:0] fast_cnt_q;
  logic [31:0] fast_cnt_d;
  always_comb fast_cnt_d = age_fast ? (age_flush ? 32'h1 : fast_cnt_q + 32'h1) : 32'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) fast_cnt_q <= 32'h0;
    else fast_cnt_q <= fast_cnt_d;
  end
  ////////////////////////////////////////
  a_dec_follows: assert property (frm_valid |=> dec_valid)
    else $error("no decision one cycle after a frame");
  a_dec_no_spur: assert property (!frm_valid |=> !dec_valid)
    else $error("decision without a frame");
  a_prio_top: assert property (frm_valid && frm_tagged && frm_user_prio == 3'h7 |=> dec_high_prio)
    else $error("top priority frame not high class");
  a_untag_low: assert property (frm_valid && !frm_tagged |=> !dec_high_prio)
    else $error("untagged frame in high class");
  a_pool_split: assert property (buf_port_limit == (buf_shared ? 16'(BUF_POOL_UNITS) : 16'(BUF_POOL_UNITS / 5)))
    else $error("port buffer limit wrong");
  a_tx_pause_gate: assert property (1'b1 |=> (tx_pause_en & ~$past(an_tx_pause)) == '0)
    else $error("tx pause on without autoneg");
  a_rx_pause_gate: assert property (1'b1 |=> (rx_pause_en & ~$past(an_rx_pause)) == '0)
    else $error("rx pause on without autoneg");
  a_flush_on_loss: assert property (|($past(link_up) & ~link_up) |=> age_flush)
    else $error("no flush after link loss");
  a_fast_starts: assert property ($rose(age_fast) |-> age_flush)
    else $error("fast aging without link loss");
  a_fast_length: assert property ($fell(age_fast) |-> fast_cnt_q == FAST_AGE_CYCLES)
    else $error("fast aging pass length wrong");
  a_miso_idle: assert property (spi_cs_n [*4] |-> spi_miso_oe_n)
    else $error("miso driven while deselected");
  c_high: cover property (frm_valid ##1 dec_high_prio);
  c_fast_end: cover property ($fell(age_fast));
  c_read: cover property ($fell(spi_miso_oe_n));
endmodule : swgc_assertions
bind swgc_top swgc_assertions #(.BUF_POOL_UNITS(BUF_POOL_UNITS), .FAST_AGE_CYCLES(FAST_AGE_CYCLES)) i_swgc_assertions (
  .clk, .rst_n, .spi_cs_n, .spi_miso_oe_n, .buf_shared, .buf_port_limit, .an_tx_pause, .an_rx_pause,
  .tx_pause_en, .rx_pause_en, .frm_valid, .frm_tagged, .frm_user_prio, .link_up, .dec_valid,
  .dec_high_prio, .age_flush, .age_fast);
`default_nettype wire

// >>> bench/swgc_spi_host.sv
// management processor model on the serial port, mode 0
`timescale 1ns/1ns
`default_nettype none
module swgc_spi_host (
  input  wire logic clk,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe_n
);
  // 5 clk half period keeps clear of the 3 clk synchroniser floor
  localparam int HALF = 5;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  ////////////////////////////////////////
  // one framed transfer, bytes msb first, one byte back per byte sent
  task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    @(negedge clk);
    spi_cs_n = 1'b0;
    repeat (HALF) @(negedge clk);
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        spi_mosi = tx[i][k];
        repeat (HALF) @(negedge clk);
        spi_sclk = 1'b1;
        // released miso has no pull, so it reads unknown
        b[k] = (spi_miso_oe_n === 1'b0) ? spi_miso : 1'bx;
        repeat (HALF) @(negedge clk);
        spi_sclk = 1'b0;
      end
      rx.push_back(b);
    end
    repeat (HALF) @(negedge clk);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    repeat (2 * HALF) @(negedge clk);
  endtask : xfer
endmodule : swgc_spi_host
`default_nettype wire

// >>> bench/tb_swgc_top.sv
// self-checking bench for the switch global control bank
`timescale 1ns/1ns
`default_nettype none
module tb_swgc_top
  import swgc_pkg::*;
;
  localparam int POOL = 1280;
  localparam int FAST = 8;
  logic                 clk, rst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n, phy_mii_oe_n;
  logic                 mii_enable_strap_pin, flow_control_strap_pin, buf_shared, pv;
  logic                 frm_valid, frm_tagged, frm_is_flow_ctrl, frm_errored, dec_valid;
  logic                 dec_high_prio, dec_drop, dec_mirror, age_flush, age_fast;
  logic [15:0]          buf_port_limit, frm_type_len, frm_payload_len;
  logic [NUM_PORTS-1:0] an_tx_pause, an_rx_pause, tx_pause_en, rx_pause_en, link_up;
  logic [2:0]           frm_user_prio, pe;
  logic [47:0]          frm_da;
  logic [31:0]          r, w;
  logic [7:0]           gc0, gc1;
  logic [7:0]           rq[$];
  int                   p, n_errors = 0, compares = 0;

  swgc_top #(.BUF_POOL_UNITS(POOL), .FAST_AGE_CYCLES(FAST)) i_swgc_top (
    .clk, .rst_n, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe_n, .mii_enable_strap_pin,
    .flow_control_strap_pin, .phy_mii_oe_n, .buf_shared, .buf_port_limit, .an_tx_pause, .an_rx_pause,
    .tx_pause_en, .rx_pause_en, .frm_valid, .frm_tagged, .frm_user_prio, .frm_type_len, .frm_da,
    .frm_is_flow_ctrl, .frm_payload_len, .frm_errored, .link_up, .dec_valid, .dec_high_prio, .dec_drop,
    .dec_mirror, .age_flush, .age_fast);
  swgc_spi_host i_swgc_spi_host (.clk, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe_n);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // straps held steady well past their capture edge
  task automatic do_reset(input logic m, input logic f);
    @(negedge clk);
    rst_n = 1'b0;
    mii_enable_strap_pin = m;
    flow_control_strap_pin = f;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    gc0 = 8'h44 | {4'h0, m, 3'h0};
    gc1 = {2'h0, f, f, 4'h0};
  endtask : do_reset

  task automatic chk_regs();
    i_swgc_spi_host.xfer({SPI_CMD_READ, REG_GC0_ADDR, 8'h00, 8'h00, 8'h00}, rq);
    chk("gc0", rq[2], gc0);
    chk("gc1", rq[3], gc1);
    chk("unmapped", rq[4], 8'h00);
    chk("phy_mii_oe_n", phy_mii_oe_n, !gc0[3]);
    chk("buf_shared", buf_shared, gc0[2]);
    chk("buf_port_limit", buf_port_limit, gc0[2] ? POOL : POOL / 5);
    chk("tx_pause_en", tx_pause_en, an_tx_pause & ~{NUM_PORTS{gc1[5]}});
    chk("rx_pause_en", rx_pause_en, an_rx_pause & ~{NUM_PORTS{gc1[4]}});
  endtask : chk_regs
  ////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h391DB1BF));
    rst_n = 1'b0;
    mii_enable_strap_pin = 1'b0;
    flow_control_strap_pin = 1'b0;
    an_tx_pause = '1;
    an_rx_pause = '1;
    link_up = '1;
    pv = 1'b0;
    {frm_valid, frm_tagged, frm_is_flow_ctrl, frm_errored, frm_user_prio, frm_type_len, frm_payload_len, frm_da} = '0;
    for (int s = 0; s < 2; s++) begin
      do_reset(s[0], s[0]);
      chk_regs();
      $display("test reset straps %0d done", s);
    end
    for (int it = 0; it < 8; it++) begin
      w = $urandom;
      w[0] = it[0];
      an_tx_pause = NUM_PORTS'($urandom);
      an_rx_pause = NUM_PORTS'($urandom);
      i_swgc_spi_host.xfer({SPI_CMD_WRITE, REG_GC0_ADDR, w[7:0], w[15:8], w[23:16]}, rq);
      gc0 = w[7:0];
      gc1 = w[15:8] & 8'hF8;
      // unknown command: no answer, no write
      i_swgc_spi_host.xfer({8'h07, REG_GC0_ADDR, ~w[7:0]}, rq);
      chk("unknown cmd", rq[2], 8'hXX);
      chk_regs();
      for (int n = 0; n <= 40; n++) begin
        @(negedge clk);
        chk("dec_valid", dec_valid, pv);
        if (pv) chk("decision", {dec_high_prio, dec_drop, dec_mirror}, pe);
        r = $urandom;
        frm_payload_len = 16'($urandom_range(1600, 1400));
        frm_valid = (r[0] | r[1]) && n < 40;
        frm_tagged = r[2];
        frm_user_prio = r[5:3];
        frm_is_flow_ctrl = r[6];
        frm_errored = r[7];
        frm_type_len = r[8] ? frm_payload_len + 16'(r[10]) : (r[9] ? PAUSE_TYPE : 16'h0800);
        frm_da = r[11] ? PAUSE_DA : {16'h0000, $urandom};
        pv = frm_valid;
        pe[2] = frm_tagged && frm_user_prio >= gc0[6:4];
        pe[1] = (gc0[1] ? (frm_type_len == PAUSE_TYPE || frm_da == PAUSE_DA) : frm_is_flow_ctrl)
          || (gc1[3] && frm_type_len < 16'h05DC && frm_type_len != frm_payload_len) || (frm_errored && !gc1[7]);
        pe[0] = gc1[7];
      end
      p = $urandom_range(NUM_PORTS - 1, 0);
      link_up[p] = 1'b0;
      for (int k = 0; k < FAST + 2; k++) begin
        @(negedge clk);
        chk("age_flush", age_flush, k == 0);
        chk("age_fast", age_fast, gc0[0] && k < FAST);
      end
      link_up[p] = 1'b1;
      $display("test config %0d done", it);
    end
    end_of_test();
  end
endmodule : tb_swgc_top
`default_nettype wire
